// ### rtl/ppfi_host.sv
`timescale 1ns/1ps
// How it works
// - drive data only with output enable high; read with select and enable low
// - write cycle: select and write strobe low, output enable held high
// - page bytes follow back to back, far inside the byte load window
// - one page per load: upper address fixed, low seven bits pick the byte
// - protected page loads are prefixed by the three byte unlock sequence
// - identification read with the high voltage pin raised, strobe high
// - identification entry uses the short three byte sequence
// - chip erase bytes go out in their fixed order
module ppfi_host
  import ppfi_pkg::*;
#(
  parameter int PWRUP_CYCLES = PWRUP_CYC,
  parameter int WRITE_CYCLES = PAGE_WRITE_CYC,
  parameter int WINDOW_CYCLES = LOAD_WINDOW_CYC
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // flash pins
  output logic [17:0] FL_ADDR,
  output logic [7:0] FL_DQ_OUT,
  output logic FL_DQ_OE,
  input wire logic [7:0] FL_DQ_IN,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic FL_ID_HV
);
  typedef enum logic [3:0] {
    S_PWRUP = 4'h0,
    S_IDLE = 4'h1,
    S_ADDR = 4'h2,
    S_DATA = 4'h3,
    S_STROBE = 4'h4,
    S_HOLD = 4'h5,
    S_RD = 4'h6,
    S_WAIT = 4'h7
  } ppfi_state_t;

  ppfi_buf_if buf_bus ();

  ppfi_page_buf #(.DEPTH(PAGE_BYTES)) u_buf (
    .clk(CLK_SYS),
    .bus(buf_bus)
  );

  ppfi_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] win, next_win;
  logic [7:0] idx, next_idx;
  logic [3:0] cmd, next_cmd;
  logic prot, next_prot;
  logic idhv, next_idhv;
  logic [17:0] addr_r, next_addr_r;
  logic [7:0] wdata_r, next_wdata_r;
  logic [7:0] len_r, next_len_r;
  logic [7:0] rdata_r, next_rdata_r;
  logic done, next_done;
  logic [17:0] next_fl_addr;
  logic [7:0] next_fl_dq_out;
  logic next_fl_dq_oe, next_fl_ce_n, next_fl_oe_n, next_fl_we_n;
  logic next_fl_id_hv;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [7:0] slen, total, pidx;
  logic [22:0] sbyte;
  logic [17:0] cur_addr;
  logic [7:0] cur_data;
  logic wr_go, rd_go, mapped, start, clr_done, last;

  // number of command bytes in front of any page data
  function automatic logic [7:0] seq_len(input logic [3:0] c,
                                         input logic p);
    unique case (c)
      CMD_RAW: seq_len = 8'h01;
      CMD_PAGE: seq_len = p ? 8'h03 : 8'h00;
      CMD_PDIS: seq_len = 8'h06;
      CMD_ERASE: seq_len = 8'h06;
      CMD_IDIN: seq_len = 8'h03;
      CMD_IDOUT: seq_len = 8'h03;
      default: seq_len = 8'h00;
    endcase
  endfunction

  // address and data of one command byte
  function automatic logic [22:0] seq_byte(input logic [3:0] c,
                                           input logic [7:0] i);
    logic [7:0] third;
    logic [7:0] sixth;
    third = SEQ_EXT;
    sixth = (c == CMD_ERASE) ? SEQ_ERASE : SEQ_PDIS;
    if (c == CMD_PAGE) begin
      third = SEQ_LOAD;
    end else if (c == CMD_IDIN) begin
      third = SEQ_IDIN;
    end else if (c == CMD_IDOUT) begin
      third = SEQ_IDOUT;
    end
    unique case (i)
      8'h00: seq_byte = {SEQ_A1, SEQ_D1};
      8'h01: seq_byte = {SEQ_A2, SEQ_D2};
      8'h02: seq_byte = {SEQ_A1, third};
      8'h03: seq_byte = {SEQ_A1, SEQ_D1};
      8'h04: seq_byte = {SEQ_A2, SEQ_D2};
      default: seq_byte = {SEQ_A1, sixth};
    endcase
  endfunction

  always_comb begin
    slen = seq_len(cmd, prot);
    total = slen + ((cmd == CMD_PAGE) ? len_r : 8'h00);
    pidx = idx - slen;
    sbyte = seq_byte(cmd, idx);
    last = (idx + 8'h01) >= total;
    cur_addr = {3'h0, sbyte[22:8]};
    cur_data = sbyte[7:0];
    if (cmd == CMD_RAW) begin
      cur_addr = addr_r;
      cur_data = wdata_r;
    end else if (idx >= slen) begin
      cur_addr = {addr_r[17:7], pidx[PIDX_W-1:0]};
      cur_data = buf_bus.rdata;
    end
  end

  // apb decode
  always_comb begin
    wr_go = PSEL && PENABLE && PREADY && PWRITE;
    rd_go = PSEL && PENABLE && !PREADY;
    mapped = (PADDR == REG_CTRL) || (PADDR == REG_ADDR) ||
             (PADDR == REG_DATA) || (PADDR == REG_STATUS) ||
             (PADDR[11:9] == BUF_WIN && PADDR[1:0] == 2'h0);
    start = wr_go && PADDR == REG_CTRL && PWDATA[CTRL_START] &&
            state == S_IDLE;
    clr_done = wr_go && PADDR == REG_STATUS && PWDATA[ST_DONE];
    buf_bus.we = wr_go && PADDR[11:9] == BUF_WIN && PADDR[1:0] == 2'h0;
    buf_bus.waddr = PADDR[8:2];
    buf_bus.wdata = PWDATA[7:0];
    buf_bus.raddr = pidx[PIDX_W-1:0];
  end

  always_comb begin
    next_pready = rd_go;
    next_pslverr = rd_go && !mapped;
    next_prdata = 32'h0000_0000;
    if (rd_go && !PWRITE) begin
      unique case (PADDR)
        REG_CTRL: next_prdata = {22'h0, idhv, prot, cmd, 4'h0};
        REG_ADDR: next_prdata = {14'h0, addr_r};
        REG_DATA: next_prdata = {16'h0, len_r, wdata_r};
        REG_STATUS: next_prdata = {16'h0, rdata_r, 4'h0, win != '0,
                                   done, state != S_PWRUP,
                                   state != S_IDLE};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    next_cmd = cmd;
    next_prot = prot;
    next_idhv = idhv;
    next_addr_r = addr_r;
    next_wdata_r = wdata_r;
    next_len_r = len_r;
    if (start) begin
      next_cmd = PWDATA[7:4];
      next_prot = PWDATA[CTRL_PROT];
      next_idhv = PWDATA[CTRL_IDHV];
    end
    if (wr_go && PADDR == REG_ADDR) begin
      next_addr_r = PWDATA[17:0];
    end
    if (wr_go && PADDR == REG_DATA) begin
      next_wdata_r = PWDATA[7:0];
      next_len_r = PWDATA[15:8];
    end
  end

  // pin sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_idx = idx;
    next_rdata_r = rdata_r;
    next_done = done && !clr_done;
    next_win = (win != '0) ? win - 1'b1 : win;
    next_fl_addr = FL_ADDR;
    next_fl_dq_out = FL_DQ_OUT;
    next_fl_dq_oe = FL_DQ_OE;
    next_fl_ce_n = FL_CE_N;
    next_fl_oe_n = FL_OE_N;
    next_fl_we_n = FL_WE_N;
    next_fl_id_hv = FL_ID_HV;
    unique case (state)
      S_PWRUP: begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        next_idx = 8'h00;
        if (start && PWDATA[7:4] == CMD_READ) begin
          next_state = S_RD;
          next_cnt = CNT_W'(RD_CYC);
          next_fl_addr = addr_r;
          next_fl_ce_n = 1'b0;
          next_fl_oe_n = 1'b0;
          next_fl_id_hv = PWDATA[CTRL_IDHV];
        end else if (start) begin
          next_state = S_ADDR;
        end
      end
      S_ADDR: begin
        next_fl_addr = cur_addr;
        next_fl_oe_n = 1'b1;
        next_fl_ce_n = 1'b0;
        next_state = S_DATA;
      end
      S_DATA: begin
        next_fl_dq_out = cur_data;
        next_fl_dq_oe = 1'b1;
        next_fl_we_n = 1'b0;
        next_cnt = CNT_W'(WE_LOW_CYC - 1);
        next_state = S_STROBE;
      end
      S_STROBE: begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_fl_we_n = 1'b1;
          next_state = S_HOLD;
        end
      end
      S_HOLD: begin
        next_fl_ce_n = 1'b1;
        next_fl_dq_oe = 1'b0;
        next_idx = idx + 8'h01;
        next_win = CNT_W'(WINDOW_CYCLES);
        if (!last) begin
          next_state = S_ADDR;
        end else if (cmd == CMD_RAW) begin
          next_state = S_IDLE;
          next_done = 1'b1;
        end else begin
          next_state = S_WAIT;
          next_cnt = CNT_W'(WRITE_CYCLES);
        end
      end
      S_RD: begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_rdata_r = FL_DQ_IN;
          next_fl_ce_n = 1'b1;
          next_fl_oe_n = 1'b1;
          next_fl_id_hv = 1'b0;
          next_done = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_WAIT: begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_done = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state <= S_PWRUP;
      cnt <= CNT_W'(PWRUP_CYCLES);
      win <= '0;
      idx <= 8'h00;
      cmd <= CMD_READ;
      prot <= 1'b0;
      idhv <= 1'b0;
      addr_r <= '0;
      wdata_r <= 8'h00;
      len_r <= LEN_RST;
      rdata_r <= 8'h00;
      done <= 1'b0;
      FL_ADDR <= '0;
      FL_DQ_OUT <= 8'h00;
      FL_DQ_OE <= 1'b0;
      FL_CE_N <= 1'b1;
      FL_OE_N <= 1'b1;
      FL_WE_N <= 1'b1;
      FL_ID_HV <= 1'b0;
      PRDATA <= CTRL_RST;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      win <= next_win;
      idx <= next_idx;
      cmd <= next_cmd;
      prot <= next_prot;
      idhv <= next_idhv;
      addr_r <= next_addr_r;
      wdata_r <= next_wdata_r;
      len_r <= next_len_r;
      rdata_r <= next_rdata_r;
      done <= next_done;
      FL_ADDR <= next_fl_addr;
      FL_DQ_OUT <= next_fl_dq_out;
      FL_DQ_OE <= next_fl_dq_oe;
      FL_CE_N <= next_fl_ce_n;
      FL_OE_N <= next_fl_oe_n;
      FL_WE_N <= next_fl_we_n;
      FL_ID_HV <= next_fl_id_hv;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end
endmodule

// ### rtl/ppfi_pkg.sv
package ppfi_pkg;
  // clock and pin timing
  localparam int CLK_NS = 40;
  localparam int WE_LOW_NS = 15;
  localparam int RD_ACC_NS = 120;
  localparam int LOAD_WINDOW_US = 200;
  localparam int PAGE_WRITE_MS = 10;
  localparam int PWRUP_MS = 5;
  localparam int WE_LOW_RAW = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_LOW_CYC = (WE_LOW_RAW < 1) ? 1 : WE_LOW_RAW;
  localparam int RD_CYC = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_US * 1000 / CLK_NS;
  localparam int PAGE_WRITE_CYC = PAGE_WRITE_MS * 1000000 / CLK_NS;
  localparam int PWRUP_CYC = PWRUP_MS * 1000000 / CLK_NS;
  localparam int CNT_W = 20;
  // flash geometry
  localparam int FA_W = 18;
  localparam int PAGE_BYTES = 128;
  localparam int PIDX_W = 7;
  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_DATA = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [2:0] BUF_WIN = 3'h1;
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_PROT = 8;
  localparam int CTRL_IDHV = 9;
  localparam int ST_BUSY = 0;
  localparam int ST_READY = 1;
  localparam int ST_DONE = 2;
  localparam int ST_WIN = 3;
  // command codes
  localparam logic [3:0] CMD_READ = 4'h0;
  localparam logic [3:0] CMD_RAW = 4'h1;
  localparam logic [3:0] CMD_PAGE = 4'h2;
  localparam logic [3:0] CMD_PDIS = 4'h3;
  localparam logic [3:0] CMD_ERASE = 4'h4;
  localparam logic [3:0] CMD_IDIN = 4'h5;
  localparam logic [3:0] CMD_IDOUT = 4'h6;
  // command sequence bytes
  localparam logic [14:0] SEQ_A1 = 15'h5555;
  localparam logic [14:0] SEQ_A2 = 15'h2AAA;
  localparam logic [7:0] SEQ_D1 = 8'hAA;
  localparam logic [7:0] SEQ_D2 = 8'h55;
  localparam logic [7:0] SEQ_LOAD = 8'hA0;
  localparam logic [7:0] SEQ_EXT = 8'h80;
  localparam logic [7:0] SEQ_IDIN = 8'h90;
  localparam logic [7:0] SEQ_IDOUT = 8'hF0;
  localparam logic [7:0] SEQ_PDIS = 8'h20;
  localparam logic [7:0] SEQ_ERASE = 8'h10;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] LEN_RST = 8'h80;
endpackage

// ### rtl/ppfi_buf_if.sv
`timescale 1ns/1ps
interface ppfi_buf_if;
  logic we;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic [6:0] raddr;
  logic [7:0] rdata;
  modport user (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
               output rdata);
endinterface

// ### rtl/ppfi_page_buf.sv
`timescale 1ns/1ps
module ppfi_page_buf
  import ppfi_pkg::*;
#(
  parameter int DEPTH = PAGE_BYTES
) (
  input wire logic clk,
  ppfi_buf_if.mem bus
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata;
  logic [7:0] next_rdata;

  // one write port, registered read port
  always_comb begin
    next_rdata = mem[bus.raddr];
  end

  always_ff @(posedge clk) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
    rdata <= next_rdata;
  end

  assign bus.rdata = rdata;
endmodule

// ### dv/ppfi_host_monitor.sv
`timescale 1ns/1ps
module ppfi_host_monitor #(
  parameter int PWRUP_CYCLES = 20
) (
  // clock, reset and apb
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // flash pins
  input wire logic [17:0] FL_ADDR,
  input wire logic [7:0] FL_DQ_OUT,
  input wire logic FL_DQ_OE,
  input wire logic FL_CE_N,
  input wire logic FL_OE_N,
  input wire logic FL_WE_N,
  input wire logic FL_ID_HV
);
  logic [31:0] up_cnt;
  logic [31:0] next_up_cnt;
  always_comb next_up_cnt = RST_N ? up_cnt + {31'h0, ~up_cnt[31]} : 32'h0;
  always_ff @(posedge CLK_SYS) up_cnt <= next_up_cnt;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence wr_release;
    !FL_CE_N && FL_DQ_OE ##1 FL_CE_N && !FL_DQ_OE;
  endsequence
  sequence addr_held;
    $stable(FL_ADDR) ##1 $stable(FL_ADDR) && $stable(FL_DQ_OUT)
      ##1 $stable(FL_ADDR) && $stable(FL_DQ_OUT);
  endsequence
  a_dq_gate: assert property (
    FL_DQ_OE |-> FL_OE_N && !FL_CE_N) else $error("dq driven in read");
  a_write_pins: assert property (
    !FL_WE_N |-> !FL_CE_N && FL_OE_N) else $error("strobe outside write");
  a_byte_frame: assert property (
    $fell(FL_WE_N) |-> FL_DQ_OE ##1 FL_WE_N ##0 wr_release)
    else $error("bad byte frame");
  a_addr_hold: assert property (
    $fell(FL_WE_N) |-> addr_held) else $error("address or data moved");
  a_id_read: assert property (
    $rose(FL_ID_HV) |-> !FL_CE_N && !FL_OE_N && FL_WE_N)
    else $error("id pin raised outside read");
  a_read_hold: assert property (
    $fell(FL_OE_N) |=> (!FL_OE_N && !FL_CE_N && $stable(FL_ADDR)) [*3])
    else $error("read cut short");
  a_apb_wait: assert property (
    PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY ##1 !PREADY)
    else $error("apb wait state wrong");
  a_err_pair: assert property (
    PSLVERR |-> PREADY) else $error("error without ready");
  a_pwrup_quiet: assert property (
    $fell(FL_WE_N) |-> up_cnt > PWRUP_CYCLES) else $error("early write");
endmodule

// ### dv/ppfi_flash_model.sv
`timescale 1ns/1ps
module ppfi_flash_model #(
  parameter int WIN_NS = 300,
  parameter int BUSY_NS = 4000,
  parameter int PWR_NS = 600,
  parameter logic [7:0] MAKER = 8'h3C, // arbitrary
  parameter logic [7:0] PART = 8'hC3, // arbitrary
  parameter logic [7:0] LOCK_D = 8'h40 // arbitrary
) (
  // device pins
  input wire logic [17:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic id_hv
);
  logic [7:0] mem [int];
  logic [7:0] pbuf [128];
  logic [127:0] ld = '0;
  logic [17:0] la, last_a;
  logic [7:0] last_d;
  logic [10:0] pg;
  logic [1:0] st = 2'h0;
  logic prot = 1'h0;
  logic unl = 1'h0, idm = 1'h0, ext = 1'h0, tgl = 1'h0, loading = 1'h0;
  logic lock_lo = 1'h0, lock_hi = 1'h0, lk = 1'h0;
  realtime t_fall = 0, t_last = 0, t_busy = 0;
  task automatic take(input logic [17:0] a, input logic [7:0] d);
    logic [14:0] c;
    c = a[14:0];
    if ($realtime < PWR_NS || $realtime < t_busy) return;
    if (st == 2'h0 && c == 15'h5555 && d == 8'hAA) st = 2'h1;
    else if (st == 2'h1 && c == 15'h2AAA && d == 8'h55) st = 2'h2;
    else if (st == 2'h2 && c == 15'h5555) begin
      st = 2'h0;
      case (d)
        8'hA0: {prot, unl} = 2'h3;
        8'h90: idm = 1'h1;
        8'hF0: idm = 1'h0;
        8'h20: if (ext) prot = 1'h0;
        8'h10: if (ext && !lock_lo && !lock_hi) mem.delete();
        LOCK_D: lk = ext;
        default: ;
      endcase
      ext = (d == 8'h80);
    end else begin
      st = 2'h0;
      if (lk) begin
        lk = 1'h0;
        lock_lo = lock_lo | (a < 18'h2000);
        lock_hi = lock_hi | (a >= 18'h3E000);
        return;
      end
      if ((prot && !unl) || idm) return;
      if (loading && a[17:7] != pg) return;
      if ((a < 18'h2000 && lock_lo) || (a >= 18'h3E000 && lock_hi)) return;
      pg = a[17:7];
      pbuf[a[6:0]] = d;
      ld[a[6:0]] = 1'h1;
      {loading, last_a, last_d} = {1'h1, a, d};
      t_last = $realtime;
    end
  endtask
  always #20 if (loading && $realtime - t_last > WIN_NS) begin
    for (int i = 0; i < 128; i++) mem[{pg, 7'(i)}] = ld[i] ? pbuf[i] : 8'hFF;
    {ld, loading, unl} = '0;
    t_busy = $realtime + BUSY_NS;
  end
  always @(negedge we_n) begin
    t_fall = $realtime;
    if (!ce_n && oe_n) la = addr;
  end
  always @(posedge we_n) begin
    if (!ce_n && oe_n && $realtime - t_fall >= 15) take(la, dq_in);
  end
  always @(negedge (ce_n | oe_n)) if ($realtime < t_busy) tgl = !tgl;
  function automatic logic [7:0] look(input logic [17:0] a, input logic s);
    if (s && a == 18'h0) return MAKER;
    if (s && a == 18'h1) return PART;
    if (s && a == 18'h2) return lock_lo ? 8'hFF : 8'hFE;
    if (s && a == 18'h3FFF2) return lock_hi ? 8'hFF : 8'hFE;
    if ($realtime < t_busy && a == last_a) return {~last_d[7], tgl, last_d[5:0]};
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  assign dq = (!ce_n && !oe_n) ? look(addr, idm || id_hv) : ~look(addr, tgl);
endmodule

// ### dv/ppfi_host_tb_top.sv
`timescale 1ns/1ps
module ppfi_host_tb_top
  import ppfi_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary
  localparam logic [7:0] PART = 8'hC3; // arbitrary
  localparam logic [7:0] LOCK_D = 8'h40; // arbitrary
  logic clk_sys, rst_n, psel, penable, pwrite, last_err, pready, pslverr;
  logic fl_dq_oe, ce_n, oe_n, we_n, id_hv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [17:0] fl_addr;
  logic [7:0] fl_dq_out, dev_dq, dq_bus;
  int n_mismatch = 0;
  int check_count = 0;
  assign dq_bus = fl_dq_oe ? fl_dq_out : dev_dq;
  ppfi_host #(.PWRUP_CYCLES(20), .WRITE_CYCLES(150), .WINDOW_CYCLES(50))
    i_ppfi_host (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FL_ADDR(fl_addr),
    .FL_DQ_OUT(fl_dq_out), .FL_DQ_OE(fl_dq_oe), .FL_DQ_IN(dq_bus),
    .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_ID_HV(id_hv));
  ppfi_flash_model #(.MAKER(MAKER), .PART(PART), .LOCK_D(LOCK_D))
    i_ppfi_flash_model (
    .addr(fl_addr), .dq_in(dq_bus), .dq(dev_dq), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .id_hv(id_hv));
  always #20 clk_sys = ~clk_sys;
  task automatic end_sim();
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic lim(input int n, input int m);
    if (n >= m) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 20);
    lim(n, 20);
    r = prdata;
    last_err = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge clk_sys);
  endtask
  task automatic run(input logic [3:0] c, input logic [1:0] f);
    logic [31:0] s;
    int n;
    apb(1'h1, REG_CTRL, {22'h0, f, c, 4'h1}, s);
    n = 0;
    do begin
      apb(1'h0, REG_STATUS, 32'h0, s);
      n++;
    end while (s[ST_DONE] !== 1'h1 && n < 100);
    lim(n, 100);
    apb(1'h1, REG_STATUS, 32'h4, s);
  endtask
  task automatic put(input logic [17:0] a, input logic [7:0] d,
                     input logic [7:0] len);
    logic [31:0] s;
    apb(1'h1, REG_ADDR, {14'h0, a}, s);
    apb(1'h1, REG_DATA, {16'h0, len, d}, s);
  endtask
  task automatic fread(input logic [17:0] a, input logic [1:0] f,
                       output logic [7:0] r);
    logic [31:0] s;
    apb(1'h1, REG_ADDR, {14'h0, a}, s);
    run(CMD_READ, f);
    apb(1'h0, REG_STATUS, 32'h0, s);
    r = s[15:8];
  endtask
  task automatic poll(input logic [17:0] a, input logic [7:0] d,
                      input logic busy);
    logic [7:0] r1, r2;
    logic inv, tog;
    int n;
    {inv, tog, n} = '0;
    fread(a, 2'h0, r2);
    do begin
      r1 = r2;
      fread(a, 2'h0, r2);
      inv = inv | (r1[7] !== d[7]);
      tog = tog | (r1[6] !== r2[6]);
      n++;
    end while (r1 !== r2 && n < 20);
    lim(n, 20);
    chk(r2, d);
    chk(inv, busy);
    chk(tog, busy);
  endtask
  task automatic t_reset();
    logic [31:0] s;
    int n;
    apb(1'h0, REG_STATUS, 32'h0, s);
    chk(s[ST_READY], 1'h0);
    apb(1'h0, 12'h100, 32'h0, s);
    chk({last_err, s}, {1'h1, 32'h0});
    n = 0;
    do begin
      apb(1'h0, REG_STATUS, 32'h0, s);
      n++;
    end while (s[ST_READY] !== 1'h1 && n < 50);
    lim(n, 50);
  endtask
  task automatic t_page();
    logic [31:0] s;
    logic [7:0] r;
    for (int i = 0; i < 3; i++) apb(1'h1, 12'h200 + 12'(4 * i), 32'h10 + i, s);
    put(18'h280, 8'h00, 8'h03);
    run(CMD_PAGE, 2'h0);
    fread(18'h281, 2'h0, r);
    chk(r, 8'h11);
    fread(18'h2FF, 2'h0, r);
    chk(r, 8'hFF);
  endtask
  task automatic t_prot();
    logic [31:0] s;
    put(18'h300, 8'h00, 8'h03);
    run(CMD_PAGE, 2'h1);
    apb(1'h0, REG_CTRL, 32'h0, s);
    chk(s, {22'h0, 1'h0, 1'h1, CMD_PAGE, 4'h0});
    put(18'h300, 8'h77, 8'h01);
    run(CMD_RAW, 2'h0);
    poll(18'h300, 8'h10, 1'h0);
    run(CMD_PDIS, 2'h0);
    put(18'h300, 8'h5A, 8'h01);
    run(CMD_RAW, 2'h0);
    poll(18'h300, 8'h5A, 1'h1);
  endtask
  task automatic t_id();
    logic [17:0] ia [4] = '{18'h0, 18'h1, 18'h2, 18'h3FFF2};
    logic [7:0] iv [4] = '{MAKER, PART, 8'hFE, 8'hFE};
    logic [7:0] r;
    run(CMD_IDIN, 2'h0);
    for (int i = 0; i < 4; i++) begin
      fread(ia[i], 2'h0, r);
      chk(r, iv[i]);
    end
    run(CMD_IDOUT, 2'h0);
    fread(18'h0, 2'h0, r);
    chk(r, 8'hFF);
    fread(18'h1, 2'h2, r);
    chk(r, PART);
    run(CMD_ERASE, 2'h0);
    fread(18'h281, 2'h0, r);
    chk(r, 8'hFF);
  endtask
  task automatic t_lock();
    logic [17:0] sa [7] = '{18'h5555, 18'h2AAA, 18'h5555, 18'h5555,
                            18'h2AAA, 18'h5555, 18'h0};
    logic [7:0] sd [7] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, LOCK_D, 8'h00};
    logic [7:0] r;
    for (int i = 0; i < 7; i++) begin
      put(sa[i], sd[i], 8'h01);
      run(CMD_RAW, 2'h0);
    end
    put(18'h4000, 8'h33, 8'h01);
    run(CMD_RAW, 2'h0);
    poll(18'h4000, 8'h33, 1'h1);
    put(18'h100, 8'h44, 8'h01);
    run(CMD_RAW, 2'h0);
    run(CMD_ERASE, 2'h0);
    run(CMD_IDIN, 2'h0);
    fread(18'h2, 2'h0, r);
    chk(r, 8'hFF);
    run(CMD_IDOUT, 2'h0);
    fread(18'h100, 2'h0, r);
    chk(r, 8'hFF);
    fread(18'h4000, 2'h0, r);
    chk(r, 8'h33);
  endtask
  initial begin
    {clk_sys, rst_n, psel, penable, pwrite} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    t_reset();
    t_page();
    t_prot();
    t_id();
    t_lock();
    end_sim();
  end
endmodule
bind ppfi_host ppfi_host_monitor #(.PWRUP_CYCLES(PWRUP_CYCLES))
  i_ppfi_host_monitor (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .FL_ADDR(FL_ADDR), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE),
  .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
  .FL_ID_HV(FL_ID_HV));
